//--- otp_sfdp_pkg.sv
package otp_sfdp_pkg;

  // ----------------------------------------------------------------
  // Command opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_ENTER_SECURE = 8'h3A;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_PARAM_READ = 8'h5A;
  localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
  localparam logic [7:0] OP_BLOCK32_ERASE = 8'h52;
  localparam logic [7:0] OP_BLOCK64_ERASE = 8'hD8;
  localparam logic [7:0] OP_CHIP_ERASE_A = 8'hC7;
  localparam logic [7:0] OP_CHIP_ERASE_B = 8'h60;
  localparam logic [7:0] OP_BANK_ERASE = 8'hD0;
  localparam logic [7:0] OP_HALF_BANK_ERASE = 8'hD1;
  localparam logic [7:0] OP_SUSPEND = 8'hB0;
  localparam logic [7:0] OP_RESUME = 8'h30;
  localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02;

  // ----------------------------------------------------------------
  // Secure sector placement
  // ----------------------------------------------------------------
  localparam logic [23:0] SECURE_FIRST = 24'h03F000;
  localparam logic [23:0] SECURE_LAST = 24'h03F1FF;

  // ----------------------------------------------------------------
  // Frame bit counts
  // ----------------------------------------------------------------
  localparam logic [4:0] OPCODE_LAST_BIT = 5'h07;
  localparam logic [4:0] ADDR_LAST_BIT = 5'h17;
  localparam logic [4:0] DUMMY_LAST_BIT = 5'h07;
  localparam logic [2:0] BYTE_LAST_BIT = 3'h7;

  // ----------------------------------------------------------------
  // Parameter space contents
  // ----------------------------------------------------------------
  localparam logic [7:0] PARAM_BLANK = 8'hFF;
  localparam logic [7:0] SIG_B0 = 8'h53;
  localparam logic [7:0] SIG_B1 = 8'h46;
  localparam logic [7:0] SIG_B2 = 8'h44;
  localparam logic [7:0] SIG_B3 = 8'h50;
  localparam logic [7:0] FMT_MINOR = 8'h00;
  localparam logic [7:0] FMT_MAJOR = 8'h01;
  localparam logic [7:0] HEADER_COUNT_FIELD = 8'h00;
  localparam logic [7:0] TABLE_ID = 8'h00;
  localparam logic [7:0] TABLE_MINOR = 8'h00;
  localparam logic [7:0] TABLE_MAJOR = 8'h01;
  localparam logic [7:0] TABLE_WORDS = 8'h09;
  localparam logic [23:0] TABLE_POINTER_FIELD = 24'h000030;
  localparam logic [1:0] ERASE_GRAIN = 2'h1;
  localparam logic WRITE_GRAIN = 1'b1;
  localparam logic [1:0] WREN_SELECT = 2'h0;
  localparam logic [2:0] UPPER_UNUSED = 3'h7;
  localparam logic [7:0] ERASE_4K_OPCODE = 8'h20;

endpackage

//--- param_table.sv
`timescale 1ns/100ps
`default_nettype none

module param_table (
  // Lookup
  input wire logic [23:0] addr_i,
  output logic [7:0] data_o
);

  always_comb begin
    data_o = otp_sfdp_pkg::PARAM_BLANK;
    unique case (addr_i)
      24'h000000: data_o = otp_sfdp_pkg::SIG_B0;
      24'h000001: data_o = otp_sfdp_pkg::SIG_B1;
      24'h000002: data_o = otp_sfdp_pkg::SIG_B2;
      24'h000003: data_o = otp_sfdp_pkg::SIG_B3;
      24'h000004: data_o = otp_sfdp_pkg::FMT_MINOR;
      24'h000005: data_o = otp_sfdp_pkg::FMT_MAJOR;
      24'h000006: data_o = otp_sfdp_pkg::HEADER_COUNT_FIELD;
      24'h000007: data_o = otp_sfdp_pkg::PARAM_BLANK;
      24'h000008: data_o = otp_sfdp_pkg::TABLE_ID;
      24'h000009: data_o = otp_sfdp_pkg::TABLE_MINOR;
      24'h00000A: data_o = otp_sfdp_pkg::TABLE_MAJOR;
      24'h00000B: data_o = otp_sfdp_pkg::TABLE_WORDS;
      24'h00000C: data_o = otp_sfdp_pkg::TABLE_POINTER_FIELD[7:0];
      24'h00000D: data_o = otp_sfdp_pkg::TABLE_POINTER_FIELD[15:8];
      24'h00000E: data_o = otp_sfdp_pkg::TABLE_POINTER_FIELD[23:16];
      24'h00000F: data_o = otp_sfdp_pkg::PARAM_BLANK;
      24'h000030: data_o = {otp_sfdp_pkg::UPPER_UNUSED, otp_sfdp_pkg::WREN_SELECT,
                            otp_sfdp_pkg::WRITE_GRAIN, otp_sfdp_pkg::ERASE_GRAIN};
      24'h000031: data_o = otp_sfdp_pkg::ERASE_4K_OPCODE;
      default: data_o = otp_sfdp_pkg::PARAM_BLANK;
    endcase
  end

endmodule

`default_nettype wire

//--- otp_mode_and_sfdp_read.sv
`timescale 1ns/100ps
`default_nettype none

module otp_mode_and_sfdp_read (
  // Core clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Serial link
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic si_i,
  output logic so_o,
  output logic so_oe_o,
  // Core status
  input wire logic busy_i,
  input wire logic otp_lock_i,
  input wire logic status_protect_bit_i,
  output logic status_protect_bit_o,
  output logic secure_mode_o,
  // Command event
  output logic cmd_valid_o,
  output logic [7:0] cmd_opcode_o,
  output logic cmd_ignored_o,
  // Array access check
  input wire logic req_valid_i,
  input wire logic [7:0] req_opcode_i,
  input wire logic [23:0] req_addr_i,
  output logic req_grant_o,
  output logic req_deny_o,
  output logic req_secure_o,
  output logic [8:0] req_offset_o
);

  // ----------------------------------------------------------------
  // Types and helpers
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    LINK_OPCODE = 3'b000,
    LINK_ADDR = 3'b001,
    LINK_DUMMY = 3'b010,
    LINK_DATA = 3'b011,
    LINK_IDLE = 3'b100
  } link_state_type;

  function automatic logic is_erase(input logic [7:0] op);
    is_erase = (op == otp_sfdp_pkg::OP_SECTOR_ERASE) ||
               (op == otp_sfdp_pkg::OP_BLOCK32_ERASE) ||
               (op == otp_sfdp_pkg::OP_BLOCK64_ERASE);
  endfunction

  function automatic logic is_disabled(input logic [7:0] op);
    is_disabled = (op == otp_sfdp_pkg::OP_CHIP_ERASE_A) ||
                  (op == otp_sfdp_pkg::OP_CHIP_ERASE_B) ||
                  (op == otp_sfdp_pkg::OP_BANK_ERASE) ||
                  (op == otp_sfdp_pkg::OP_HALF_BANK_ERASE) ||
                  (op == otp_sfdp_pkg::OP_SUSPEND) ||
                  (op == otp_sfdp_pkg::OP_RESUME);
  endfunction

  function automatic logic in_secure(input logic [23:0] a);
    in_secure = (a >= otp_sfdp_pkg::SECURE_FIRST) && (a <= otp_sfdp_pkg::SECURE_LAST);
  endfunction

  // ----------------------------------------------------------------
  // Link domain: shifter and frame control
  // ----------------------------------------------------------------
  // Deselect clears the link shifter, frame state and output, so a raised chip select
  // ends any frame wherever it stands.
  logic link_rst;
  assign link_rst = rst_i | cs_n_i;

  link_state_type state;
  link_state_type next_state;
  logic [4:0] bit_cnt;
  logic [4:0] next_bit_cnt;
  logic [7:0] shift_in;
  logic [7:0] next_shift_in;
  logic [23:0] rd_addr;
  logic [23:0] next_rd_addr;
  logic [7:0] cmd_code;
  logic [7:0] next_cmd_code;
  logic cmd_toggle;
  logic next_cmd_toggle;
  logic busy_meta;
  logic busy_link;
  logic [7:0] table_byte;

  param_table u_table (
    .addr_i(rd_addr),
    .data_o(table_byte)
  );

  always_comb begin
    next_state = state;
    next_bit_cnt = bit_cnt + 5'h01;
    next_shift_in = {shift_in[6:0], si_i};
    next_rd_addr = rd_addr;
    next_cmd_code = cmd_code;
    next_cmd_toggle = cmd_toggle;
    unique case (state)
      LINK_OPCODE: begin
        if (bit_cnt == otp_sfdp_pkg::OPCODE_LAST_BIT) begin
          next_bit_cnt = 5'h00;
          next_cmd_code = next_shift_in;
          next_cmd_toggle = ~cmd_toggle;
          if (next_shift_in == otp_sfdp_pkg::OP_PARAM_READ && !busy_link) begin
            next_state = LINK_ADDR;
          end else begin
            next_state = LINK_IDLE;
          end
        end
      end
      LINK_ADDR: begin
        next_rd_addr = {rd_addr[22:0], si_i};
        if (bit_cnt == otp_sfdp_pkg::ADDR_LAST_BIT) begin
          next_bit_cnt = 5'h00;
          next_state = LINK_DUMMY;
        end
      end
      LINK_DUMMY: begin
        if (bit_cnt == otp_sfdp_pkg::DUMMY_LAST_BIT) begin
          next_bit_cnt = 5'h00;
          next_state = LINK_DATA;
        end
      end
      LINK_DATA: begin
        next_bit_cnt = {2'b00, bit_cnt[2:0] + 3'h1};
        if (bit_cnt[2:0] == otp_sfdp_pkg::BYTE_LAST_BIT) begin
          // Plain 24-bit add rolls over to zero at the top
          next_rd_addr = rd_addr + 24'h000001;
        end
      end
      LINK_IDLE: begin
        // Refused frame stays silent until deselect
        next_bit_cnt = bit_cnt;
      end
      default: begin
        next_state = LINK_IDLE;
        next_bit_cnt = bit_cnt;
      end
    endcase
  end

  always_ff @(posedge sclk_i or posedge link_rst) begin
    if (link_rst) begin
      state <= LINK_OPCODE;
      bit_cnt <= 5'h00;
      shift_in <= 8'h00;
      rd_addr <= 24'h000000;
    end else begin
      state <= next_state;
      bit_cnt <= next_bit_cnt;
      shift_in <= next_shift_in;
      rd_addr <= next_rd_addr;
    end
  end

  // ----------------------------------------------------------------
  // Link domain: command capture and busy sync
  // ----------------------------------------------------------------
  // Command code and toggle survive deselect for the core to read
  // Busy sync moves only on link rises, so the value
  // seen at the eighth rise belongs to the same frame
  always_ff @(posedge sclk_i or posedge rst_i) begin
    if (rst_i) begin
      cmd_code <= 8'h00;
      cmd_toggle <= 1'b0;
      busy_meta <= 1'b0;
      busy_link <= 1'b0;
    end else begin
      cmd_code <= next_cmd_code;
      cmd_toggle <= next_cmd_toggle;
      busy_meta <= busy_i;
      busy_link <= busy_meta;
    end
  end

  // ----------------------------------------------------------------
  // Link domain: falling-edge output
  // ----------------------------------------------------------------
  // Address steps at the last bit's rise, so the table
  // byte has settled before the next falling edge
  logic next_so;
  logic next_so_oe;

  always_comb begin
    next_so = 1'b0;
    next_so_oe = 1'b0;
    if (state == LINK_DATA) begin
      next_so = table_byte[otp_sfdp_pkg::BYTE_LAST_BIT - bit_cnt[2:0]];
      next_so_oe = 1'b1;
    end
  end

  always_ff @(negedge sclk_i or posedge link_rst) begin
    if (link_rst) begin
      so_o <= 1'b0;
      so_oe_o <= 1'b0;
    end else begin
      so_o <= next_so;
      so_oe_o <= next_so_oe;
    end
  end

  // ----------------------------------------------------------------
  // Core domain: command crossing and secure mode
  // ----------------------------------------------------------------
  logic tog_meta;
  logic tog_sync;
  logic tog_seen;
  logic cmd_event;
  logic secure_mode;
  logic next_secure_mode;
  logic next_cmd_valid;
  logic [7:0] next_cmd_opcode;
  logic next_cmd_ignored;
  logic next_status_bit;

  // Opcode register is stable long before the toggle is seen
  assign cmd_event = tog_sync ^ tog_seen;

  always_comb begin
    next_secure_mode = secure_mode;
    next_cmd_valid = cmd_event;
    next_cmd_opcode = cmd_opcode_o;
    next_cmd_ignored = 1'b0;
    if (cmd_event) begin
      next_cmd_opcode = cmd_code;
      if (cmd_code == otp_sfdp_pkg::OP_ENTER_SECURE) begin
        next_secure_mode = 1'b1;
      end else if (cmd_code == otp_sfdp_pkg::OP_WRITE_DISABLE) begin
        next_secure_mode = 1'b0;
      end
      // Disabled opcodes are only reported, never acted on
      next_cmd_ignored = secure_mode && is_disabled(cmd_code);
    end
    next_status_bit = secure_mode ? otp_lock_i : status_protect_bit_i;
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tog_meta <= 1'b0;
      tog_sync <= 1'b0;
      tog_seen <= 1'b0;
      secure_mode <= 1'b0;
      cmd_valid_o <= 1'b0;
      cmd_opcode_o <= 8'h00;
      cmd_ignored_o <= 1'b0;
      status_protect_bit_o <= 1'b0;
    end else begin
      tog_meta <= cmd_toggle;
      tog_sync <= tog_meta;
      tog_seen <= tog_sync;
      secure_mode <= next_secure_mode;
      cmd_valid_o <= next_cmd_valid;
      cmd_opcode_o <= next_cmd_opcode;
      cmd_ignored_o <= next_cmd_ignored;
      status_protect_bit_o <= next_status_bit;
    end
  end

  assign secure_mode_o = secure_mode;

  // ----------------------------------------------------------------
  // Core domain: array access check
  // ----------------------------------------------------------------
  logic next_grant;
  logic next_deny;
  logic next_req_secure;
  logic [8:0] next_offset;
  logic req_is_erase;
  logic req_is_program;
  logic req_hits_secure;

  always_comb begin
    req_is_erase = is_erase(req_opcode_i);
    req_is_program = (req_opcode_i == otp_sfdp_pkg::OP_PAGE_PROGRAM);
    req_hits_secure = secure_mode && in_secure(req_addr_i);
    next_grant = 1'b0;
    next_deny = 1'b0;
    next_req_secure = 1'b0;
    next_offset = 9'h000;
    if (req_valid_i) begin
      next_grant = 1'b1;
      if (secure_mode) begin
        if (is_disabled(req_opcode_i)) begin
          next_grant = 1'b0;
        end else if (req_hits_secure) begin
          next_req_secure = 1'b1;
          next_offset = req_addr_i[8:0] - otp_sfdp_pkg::SECURE_FIRST[8:0];
          if (req_is_erase && req_opcode_i != otp_sfdp_pkg::OP_SECTOR_ERASE) begin
            next_grant = 1'b0;
          end else if ((req_is_erase || req_is_program) && otp_lock_i) begin
            // Lock guards the secure sector itself as well
            next_grant = 1'b0;
          end
        end else if ((req_is_erase || req_is_program) && otp_lock_i) begin
          next_grant = 1'b0;
        end
      end
      next_deny = ~next_grant;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      req_grant_o <= 1'b0;
      req_deny_o <= 1'b0;
      req_secure_o <= 1'b0;
      req_offset_o <= 9'h000;
    end else begin
      req_grant_o <= next_grant;
      req_deny_o <= next_deny;
      req_secure_o <= next_req_secure;
      req_offset_o <= next_offset;
    end
  end

endmodule

`default_nettype wire

//--- otp_sfdp_sva.sv
`timescale 1ns/100ps
`default_nettype none

module otp_sfdp_sva (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Link
  input wire logic cs_n_i,
  input wire logic so_o,
  input wire logic so_oe_o,
  // Status and commands
  input wire logic otp_lock_i,
  input wire logic status_protect_bit_i,
  input wire logic status_protect_bit_o,
  input wire logic secure_mode_o,
  input wire logic cmd_valid_o,
  input wire logic [7:0] cmd_opcode_o,
  // Access check
  input wire logic req_valid_i,
  input wire logic [7:0] req_opcode_i,
  input wire logic [23:0] req_addr_i,
  input wire logic req_grant_o,
  input wire logic req_deny_o,
  input wire logic req_secure_o,
  input wire logic [8:0] req_offset_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  logic in_sec;
  assign in_sec = (req_addr_i >= 24'h03F000) && (req_addr_i <= 24'h03F1FF);
  sequence s_sec_req;
    req_valid_i && secure_mode_o;
  endsequence
  AST_ONE_ANSWER: assert property (req_valid_i |=> req_grant_o != req_deny_o)
    else $error("request not answered once");
  AST_OPEN_MODE: assert property (req_valid_i && !secure_mode_o |=> req_grant_o && !req_secure_o)
    else $error("normal mode request refused or mapped");
  AST_SEC_MAP: assert property (s_sec_req ##0 in_sec |=> req_secure_o && req_offset_o == $past(req_addr_i[8:0]))
    else $error("secure sector mapping wrong");
  AST_DISABLED: assert property (s_sec_req ##0 req_opcode_i inside {8'hC7, 8'h60, 8'hD0, 8'hD1, 8'hB0, 8'h30} |=> req_deny_o)
    else $error("disabled command granted");
  AST_LOCKED: assert property (s_sec_req ##0 otp_lock_i && req_opcode_i inside {8'h02, 8'h20, 8'h52, 8'hD8} |=> req_deny_o)
    else $error("write granted under lock");
  AST_SEC_ERASE: assert property (s_sec_req ##0 in_sec && !otp_lock_i && req_opcode_i inside {8'h52, 8'hD8} |=> req_deny_o)
    else $error("block erase of secure sector granted");
  AST_PROTECT_VIEW: assert property (1'b1 |=> status_protect_bit_o == ($past(secure_mode_o) ? $past(otp_lock_i) : $past(status_protect_bit_i)))
    else $error("protect bit view wrong");
  AST_MODE_SET: assert property (cmd_valid_o && cmd_opcode_o == 8'h3A |-> secure_mode_o)
    else $error("enter opcode left mode clear");
  AST_MODE_CLR: assert property (cmd_valid_o && cmd_opcode_o == 8'h04 |-> !secure_mode_o)
    else $error("write disable left mode set");
  AST_SO_IDLE: assert property (cs_n_i |-> !so_oe_o && !so_o)
    else $error("output driven while deselected");
endmodule

bind otp_mode_and_sfdp_read otp_sfdp_sva u_sva (
  .core_clk_i(core_clk_i), .rst_i(rst_i), .cs_n_i(cs_n_i), .so_o(so_o), .so_oe_o(so_oe_o),
  .otp_lock_i(otp_lock_i), .status_protect_bit_i(status_protect_bit_i),
  .status_protect_bit_o(status_protect_bit_o), .secure_mode_o(secure_mode_o),
  .cmd_valid_o(cmd_valid_o), .cmd_opcode_o(cmd_opcode_o), .req_valid_i(req_valid_i),
  .req_opcode_i(req_opcode_i), .req_addr_i(req_addr_i), .req_grant_o(req_grant_o),
  .req_deny_o(req_deny_o), .req_secure_o(req_secure_o), .req_offset_o(req_offset_o)
);

`default_nettype wire

//--- spi_host_model.sv
`timescale 1ns/100ps
`default_nettype none

module spi_host_model (
  // Serial link
  output logic sclk_o,
  output logic cs_n_o,
  output logic si_o,
  input wire logic so_i,
  input wire logic so_oe_i
);
  logic [7:0] rx [0:15];
  logic oe_seen;
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    si_o = 1'b0;
    oe_seen = 1'b0;
  end
  // Header of hdr bits, then nbits of read data; clock still outside frames
  task automatic frame(input logic [7:0] op, input logic [23:0] a, input int hdr, input int nbits);
    logic [39:0] w;
    int i;
    w = {op, a, 8'h00};
    oe_seen = 1'b0;
    cs_n_o = 1'b0;
    for (i = 0; i < hdr + nbits; i++) begin
      si_o = (i < hdr) ? w[39 - i] : ~si_o;
      #6 sclk_o = 1'b1;
      if (i >= hdr) begin
        // Undriven line reads as the inverse of its level
        rx[(i - hdr) / 8][7 - (i - hdr) % 8] = so_oe_i ? so_i : ~so_i;
        oe_seen = oe_seen | so_oe_i;
      end
      #6 sclk_o = 1'b0;
    end
    #6 cs_n_o = 1'b1;
    si_o = ~si_o;
    #24;
  endtask
endmodule

`default_nettype wire

//--- testbench.sv
`timescale 1ns/100ps
`default_nettype none

module testbench;
  logic core_clk_i, rst_i, busy_i, otp_lock_i, status_protect_bit_i, req_valid_i;
  logic [7:0] req_opcode_i, cmd_opcode_o;
  logic [23:0] req_addr_i;
  logic sclk, cs_n, si, so_o, so_oe_o, status_protect_bit_o, secure_mode_o;
  logic cmd_valid_o, cmd_ignored_o, req_grant_o, req_deny_o, req_secure_o;
  logic [8:0] req_offset_o;
  int err_count = 0;
  int tests_run = 0;
  int ign_cnt = 0;

  otp_mode_and_sfdp_read u_dut (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .sclk_i(sclk), .cs_n_i(cs_n), .si_i(si),
    .so_o(so_o), .so_oe_o(so_oe_o), .busy_i(busy_i), .otp_lock_i(otp_lock_i),
    .status_protect_bit_i(status_protect_bit_i), .status_protect_bit_o(status_protect_bit_o),
    .secure_mode_o(secure_mode_o), .cmd_valid_o(cmd_valid_o), .cmd_opcode_o(cmd_opcode_o),
    .cmd_ignored_o(cmd_ignored_o), .req_valid_i(req_valid_i), .req_opcode_i(req_opcode_i),
    .req_addr_i(req_addr_i), .req_grant_o(req_grant_o), .req_deny_o(req_deny_o),
    .req_secure_o(req_secure_o), .req_offset_o(req_offset_o)
  );
  spi_host_model u_host (.sclk_o(sclk), .cs_n_o(cs_n), .si_o(si), .so_i(so_o), .so_oe_i(so_oe_o));

  initial begin
    core_clk_i = 1'b0;
    forever #4 core_clk_i = ~core_clk_i;
  end
  always @(posedge core_clk_i) if (cmd_ignored_o === 1'b1) ign_cnt <= ign_cnt + 1;

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
    tests_run++;
    if (exp !== got) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic print_verdict;
    $display("Checks %0d, errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic rd(input logic [23:0] a, input logic [7:0] e[$]);
    u_host.frame(8'h5A, a, 40, e.size() * 8);
    foreach (e[i]) chk("param_byte", 24'(e[i]), 24'(u_host.rx[i]));
  endtask
  task automatic req(input logic [7:0] op, input logic [23:0] a, input logic g, input logic s);
    @(posedge core_clk_i);
    req_valid_i <= 1'b1;
    req_opcode_i <= op;
    req_addr_i <= a;
    @(posedge core_clk_i);
    req_valid_i <= 1'b0;
    #1;
    chk("grant", 24'(g), 24'(req_grant_o));
    chk("deny", 24'(!g), 24'(req_deny_o));
    chk("secure", 24'(s), 24'(req_secure_o));
  endtask
  task automatic wait_mode(input logic m);
    int i;
    for (i = 0; i < 40 && secure_mode_o !== m; i++) @(posedge core_clk_i);
    chk("secure_mode", 24'(m), 24'(secure_mode_o));
    if (i == 40) print_verdict;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_table;
    rd(24'h000000, '{8'h53, 8'h46, 8'h44, 8'h50, 8'h00, 8'h01, 8'h00, 8'hFF, 8'h00, 8'h00,
      8'h01, 8'h09, 8'h30, 8'h00, 8'h00, 8'hFF});
    rd(24'h00002F, '{8'hFF, 8'hE5, 8'h20, 8'hFF});
    rd(24'hFFFFFF, '{8'hFF, 8'h53, 8'h46});
  endtask
  task automatic t_stop;
    u_host.frame(8'h5A, 24'h000000, 40, 5);
    chk("partial_bits", 24'h0A, 24'(u_host.rx[0][7:3]));
    chk("oe_after_stop", 24'h0, 24'(so_oe_o));
    chk("so_after_stop", 24'h0, 24'(so_o));
  endtask
  task automatic t_busy;
    @(posedge core_clk_i) busy_i <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    u_host.frame(8'h5A, 24'h000000, 40, 16);
    chk("oe_when_busy", 24'h0, 24'(u_host.oe_seen));
    @(posedge core_clk_i) busy_i <= 1'b0;
  endtask
  task automatic t_secure;
    logic [7:0] ops [6] = '{8'hC7, 8'h60, 8'hD0, 8'hD1, 8'hB0, 8'h30};
    int n;
    req(8'h02, 24'h03F000, 1'b1, 1'b0);
    u_host.frame(8'h3A, 24'h0, 8, 0);
    wait_mode(1'b1);
    @(posedge core_clk_i) status_protect_bit_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    #1;
    chk("protect_view", 24'h0, 24'(status_protect_bit_o));
    @(posedge core_clk_i) status_protect_bit_i <= 1'b0;
    req(8'h03, 24'h03F1FF, 1'b1, 1'b1);
    chk("offset", 24'h1FF, 24'(req_offset_o));
    req(8'h20, 24'h03F004, 1'b1, 1'b1);
    req(8'h52, 24'h03F000, 1'b0, 1'b1);
    req(8'h02, 24'h010000, 1'b1, 1'b0);
    foreach (ops[i]) req(ops[i], 24'h001000, 1'b0, 1'b0);
    n = ign_cnt;
    u_host.frame(8'hC7, 24'h0, 8, 0);
    repeat (4) @(posedge core_clk_i);
    chk("ignored_count", 24'(n + 1), 24'(ign_cnt));
    @(posedge core_clk_i) otp_lock_i <= 1'b1;
    req(8'h02, 24'h010000, 1'b0, 1'b0);
    req(8'hD8, 24'h020000, 1'b0, 1'b0);
    req(8'h03, 24'h010000, 1'b1, 1'b0);
    chk("protect_view", 24'h1, 24'(status_protect_bit_o));
    u_host.frame(8'h04, 24'h0, 8, 0);
    wait_mode(1'b0);
    req(8'hC7, 24'h000000, 1'b1, 1'b0);
    chk("protect_view", 24'h0, 24'(status_protect_bit_o));
    @(posedge core_clk_i) otp_lock_i <= 1'b0;
    status_protect_bit_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    #1;
    chk("protect_view", 24'h1, 24'(status_protect_bit_o));
  endtask

  initial begin
    rst_i = 1'b1;
    busy_i = 1'b0;
    otp_lock_i = 1'b0;
    status_protect_bit_i = 1'b0;
    req_valid_i = 1'b0;
    req_opcode_i = 8'h00;
    req_addr_i = 24'h000000;
    repeat (5) @(posedge core_clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge core_clk_i);
    t_table;
    t_stop;
    t_busy;
    t_secure;
    print_verdict;
  end
endmodule

`default_nettype wire
